//--- hdl/pcm_audio_master_port.sv
// Fixed-format master serial audio port: 8 kHz long sync, 768 kHz bit clock.
//
// How it works
// R1: Frame sync pulses at 8 kHz, framing both streams.
// R2: Master only; six slots, only slot 0 used.
// R3: Bit clock 768 kHz, one clock per bit.
// R4: Sixteen-bit words, MSB first, both directions.
// R5: Linear samples only, no companding applied.
// R6: Long sync, high about 32 us, low 93.
// R7: Sync period is 125 microseconds.
// R8: Configuration fixed, no alternate formats offered.
// R9: Data output driven push-pull in both states.
// R10: Peripheral floats data input when analog path used.
// R11: Launch on rising edge, sample on falling; slots 1-5 idle.
`timescale 1ns/1ns
`include "pcm_port_params.svh"
module pcm_audio_master_port
	import pcm_port_pkg::*;
(
	// System clock and synchronous reset.
	input  wire logic    SYS_CLK_I,
	input  wire logic    SYS_RST_I,
	// Transmit samples from the device side.
	input  wire sample_t TX_DATA_I,
	input  wire logic    TX_VALID_I,
	output logic         TX_READY_O,
	// Received samples to the device side.
	output sample_t      RX_DATA_O,
	output logic         RX_VALID_O,
	// Serial pins towards the peripheral.
	output logic         PCM_SYNC_O,
	output logic         PCM_CLK_O,
	output logic         PCM_DATA_O,
	output logic         PCM_DATA_OE_O,
	input  wire logic    PCM_DATA_I
);
	localparam port_state_s_t PORT_RST = '0;
	localparam logic [`PCM_NCO_W:0]       NCO_MOD   = (`PCM_NCO_W+1)'(`PCM_NCO_MOD);
	localparam logic [`PCM_NCO_W:0]       NCO_INC   = (`PCM_NCO_W+1)'(`PCM_NCO_INC);
	localparam logic [`PCM_BIT_IDX_W-1:0] LAST_BIT  = `PCM_BIT_IDX_W'(`PCM_FRAME_BITS - 1);
	localparam logic [`PCM_BIT_IDX_W-1:0] SLOT_LO   =
		`PCM_BIT_IDX_W'(`PCM_ACTIVE_SLOT * `PCM_WORD_BITS);
	localparam logic [`PCM_BIT_IDX_W-1:0] SLOT_HI   =
		`PCM_BIT_IDX_W'((`PCM_ACTIVE_SLOT + 1) * `PCM_WORD_BITS - 1);
	localparam logic [`PCM_BIT_IDX_W-1:0] SYNC_BITS = `PCM_BIT_IDX_W'(`PCM_SYNC_HIGH_BITS);

	// True when a bit index lies inside the active slot.
	function automatic logic in_slot(input logic [`PCM_BIT_IDX_W-1:0] idx);
		in_slot = (idx >= SLOT_LO) && (idx <= SLOT_HI);
	endfunction

	port_state_s_t s_r;
	port_state_s_t s_nxt;
	logic [`PCM_NCO_W:0] acc_sum;
	logic                tick;
	logic                rise;
	logic                fall;
	sample_t             word;
	sample_t             rx_word;

	sample_stream_if #(.W(`PCM_WORD_BITS)) tx_in ();
	sample_stream_if #(.W(`PCM_WORD_BITS)) tx_out ();

	assign tx_in.valid = TX_VALID_I;
	assign tx_in.data  = TX_DATA_I;

	// Eight-entry buffer plus output register, nine words; it drains one sample per frame, so a fast source stalls.
	sample_fifo #(.W(`PCM_WORD_BITS), .DEPTH(`PCM_TX_FIFO_DEPTH)) u_tx_fifo (
		.clk_i (SYS_CLK_I),
		.rst_i (SYS_RST_I),
		.in_s  (tx_in),
		.out_s (tx_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt          = s_r;
		s_nxt.rx_valid = 1'h0;
		s_nxt.pin_meta = PCM_DATA_I;
		s_nxt.pin_sync = s_r.pin_meta;
		acc_sum        = {1'h0, s_r.acc} + NCO_INC;
		tick           = 1'h0;
		word           = `PCM_SILENCE;
		rx_word        = {s_r.rxsh[`PCM_WORD_BITS-2:0], s_r.pin_sync};
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.st  = ST_RUN;
				s_nxt.acc = '0;
			end
			ST_RUN: begin
				// Fractional divider: average edge rate is exactly twice the bit rate.
				if (acc_sum >= NCO_MOD) begin
					tick      = 1'h1; // R3
					s_nxt.acc = `PCM_NCO_W'(acc_sum - NCO_MOD);
				end else begin
					s_nxt.acc = `PCM_NCO_W'(acc_sum);
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
		rise = tick & ~s_r.clk;
		fall = tick & s_r.clk;
		tx_out.ready = rise && (s_r.bit_idx == SLOT_LO);
		if (tick) begin
			s_nxt.clk = ~s_r.clk; // R3
		end
		if (rise) begin
			// Everything towards the peripheral changes on the rising edge.
			s_nxt.cur     = s_r.bit_idx;
			s_nxt.bit_idx = (s_r.bit_idx == LAST_BIT) ? '0 : `PCM_BIT_IDX_W'(s_r.bit_idx + 1'h1);
			s_nxt.sync    = (s_r.bit_idx < SYNC_BITS); // R1 R6 R7
			s_nxt.oe      = in_slot(s_r.bit_idx); // R2 R9 R11
			if (s_r.bit_idx == SLOT_LO) begin
				// Linear word passed through untouched; silence on underrun.
				if (tx_out.valid) begin
					word = tx_out.data; // R5
				end
				s_nxt.dout = word[`PCM_WORD_BITS-1]; // R4
				s_nxt.txsh = {word[`PCM_WORD_BITS-2:0], 1'h0};
			end else if (in_slot(s_r.bit_idx)) begin
				s_nxt.dout = s_r.txsh[`PCM_WORD_BITS-1]; // R4
				s_nxt.txsh = {s_r.txsh[`PCM_WORD_BITS-2:0], 1'h0};
			end else begin
				s_nxt.dout = 1'h0; // R11
			end
		end
		if (fall && in_slot(s_r.cur)) begin
			s_nxt.rxsh = rx_word; // R4 R11
			if (s_r.cur == SLOT_HI) begin
				s_nxt.rx_data  = rx_word; // R5
				s_nxt.rx_valid = 1'h1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			s_r <= PORT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pins carry no configuration inputs: the format is fixed in hardware.
	assign PCM_SYNC_O    = s_r.sync; // R8
	assign PCM_CLK_O     = s_r.clk;
	assign PCM_DATA_O    = s_r.dout;
	assign PCM_DATA_OE_O = s_r.oe;
	assign RX_DATA_O     = s_r.rx_data;
	assign RX_VALID_O    = s_r.rx_valid;
	assign TX_READY_O    = tx_in.ready;

	////////////////////////////////////////////////////////////////////////////////
	localparam int FRAME_CYC = `PCM_FRAME_CYCLES;
	localparam int HALF_MIN  = `PCM_NCO_MOD / `PCM_NCO_INC;
	localparam int HALF_MAX  = HALF_MIN + 1;

	logic [15:0] fr_cyc;
	logic        fr_seen;
	logic [7:0]  half_cyc;
	logic [6:0]  hi_bits;
	logic        take_d;
	logic        take_msb;

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			fr_cyc   <= 16'h0000;
			fr_seen  <= 1'h0;
			half_cyc <= 8'h00;
			hi_bits  <= 7'h00;
			take_d   <= 1'h0;
			take_msb <= 1'h0;
		end else begin
			fr_cyc   <= (PCM_SYNC_O && !$past(PCM_SYNC_O)) ? 16'h0001 : 16'(fr_cyc + 1'h1);
			fr_seen  <= fr_seen | PCM_SYNC_O;
			half_cyc <= tick ? 8'h00 : 8'(half_cyc + 1'h1);
			// Counts bit periods that begin with the sync pin already high.
			if (rise) begin
				hi_bits <= PCM_SYNC_O ? 7'(hi_bits + 1'h1) : 7'h00;
			end
			take_d   <= tx_out.valid & tx_out.ready;
			take_msb <= tx_out.data[`PCM_WORD_BITS-1];
		end
	end

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_frame_period: assert property ($rose(PCM_SYNC_O) && fr_seen |-> fr_cyc == 16'(FRAME_CYC)) // R7
		else $error("Frame sync period is wrong.");
	a_sync_high_len: assert property ($fell(PCM_SYNC_O) |-> hi_bits == SYNC_BITS) // R6
		else $error("Frame sync high time is wrong.");
	a_sync_on_bit0: assert property ($rose(PCM_SYNC_O) |-> $rose(PCM_CLK_O) && s_r.cur == '0) // R1
		else $error("Frame sync not aligned to bit 0.");
	a_clk_half: assert property (tick && s_r.st == ST_RUN && fr_seen
		|-> half_cyc >= 8'(HALF_MIN - 1) && half_cyc <= 8'(HALF_MAX - 1)) // R3
		else $error("Bit clock half period out of range.");
	a_oe_slot0: assert property (PCM_DATA_OE_O |-> in_slot(s_r.cur)) // R2
		else $error("Data driven outside slot 0.");
	a_launch_rise: assert property ($changed(PCM_DATA_O) |-> $rose(PCM_CLK_O)) // R11
		else $error("Data changed away from rising edge.");
	a_msb_first: assert property (take_d |-> PCM_DATA_O == take_msb) // R4
		else $error("First bit sent is not the MSB.");
	a_rx_on_fall: assert property ($rose(RX_VALID_O) |-> $fell(PCM_CLK_O) ##1 !RX_VALID_O) // R4
		else $error("Receive word not completed on falling edge.");
	a_push_pull: assert property (PCM_DATA_OE_O |-> ##1 PCM_DATA_OE_O || $rose(PCM_CLK_O)) // R9
		else $error("Output enable dropped inside a bit.");

	c_frame: cover property ($rose(PCM_SYNC_O) && fr_seen);
	c_rx_word: cover property (RX_VALID_O);
	c_underrun: cover property (tx_out.ready && !tx_out.valid);
	c_backpressure: cover property (TX_VALID_I && !TX_READY_O);
endmodule

//--- hdl/pcm_port_params.svh
// Timing, framing and transmit buffer constants of the serial audio master port.
`ifndef PCM_PORT_PARAMS_SVH
`define PCM_PORT_PARAMS_SVH

// System clock and bit clock rates.
`define PCM_SYS_CLK_KHZ      100000
`define PCM_BIT_RATE_KHZ     768

// Phase accumulator: two bit-clock edges per bit period, in kHz units.
`define PCM_NCO_MOD          (`PCM_SYS_CLK_KHZ)
`define PCM_NCO_INC          (2 * `PCM_BIT_RATE_KHZ)
`define PCM_NCO_W            17

// Frame layout: six slots of one sixteen-bit word, only slot 0 used.
`define PCM_SLOTS            6
`define PCM_WORD_BITS        16
`define PCM_ACTIVE_SLOT      0
`define PCM_FRAME_BITS       (`PCM_SLOTS * `PCM_WORD_BITS)
`define PCM_BIT_IDX_W        7

// Frame sync times in ns; high time rounds up to whole bit periods.
`define PCM_FRAME_NS         125000
`define PCM_SYNC_HIGH_NS     32000
`define PCM_SYNC_LOW_NS      93000
`define PCM_BIT_NS           1302
`define PCM_SYNC_HIGH_BITS   ((`PCM_SYNC_HIGH_NS * `PCM_BIT_RATE_KHZ + 999999) / 1000000)
`define PCM_FRAME_CYCLES     ((`PCM_FRAME_NS / 1000) * `PCM_SYS_CLK_KHZ / 1000)

// Transmit buffer depth and silence sent when it runs dry.
`define PCM_TX_FIFO_DEPTH    8
`define PCM_SILENCE          16'h0000

`endif

//--- hdl/pcm_port_pkg.sv
// Types shared by the serial audio master port.
package pcm_port_pkg;
`include "pcm_port_params.svh"

	typedef enum logic {ST_IDLE, ST_RUN} port_state_t;

	typedef logic [`PCM_WORD_BITS-1:0] sample_t;

	typedef struct packed {
		port_state_t               st;
		logic [`PCM_NCO_W-1:0]     acc;
		logic                      clk;
		logic [`PCM_BIT_IDX_W-1:0] bit_idx;
		logic [`PCM_BIT_IDX_W-1:0] cur;
		logic                      sync;
		logic                      dout;
		logic                      oe;
		sample_t                   txsh;
		sample_t                   rxsh;
		sample_t                   rx_data;
		logic                      rx_valid;
		logic                      pin_meta;
		logic                      pin_sync;
	} port_state_s_t;
endpackage

//--- hdl/sample_fifo.sv
// Sample FIFO with registered read data and registered ready.
`timescale 1ns/1ns
module sample_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Filling and draining sides.
	sample_stream_if.snk      in_s,
	sample_stream_if.src      out_s
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
		logic                    ov;
		logic [W-1:0]            od;
	} fifo_state_t;

	localparam fifo_state_t FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
		rdy: 1'h1, ov: 1'h0, od: '0};

	fifo_state_t s_r;
	fifo_state_t s_nxt;
	logic        push;
	logic        pop;
	logic        refill;

	assign in_s.ready  = s_r.rdy;
	assign out_s.valid = s_r.ov;
	assign out_s.data  = s_r.od;

	always_comb begin
		s_nxt  = s_r;
		push   = in_s.valid & s_r.rdy;
		pop    = s_r.ov & out_s.ready;
		refill = (s_r.cnt != '0) & (~s_r.ov | pop);
		if (push) begin
			s_nxt.mem[s_r.wp] = in_s.data;
			s_nxt.wp = AW'(s_r.wp + 1'h1);
		end
		if (refill) begin
			s_nxt.od = s_r.mem[s_r.rp];
			s_nxt.ov = 1'h1;
			s_nxt.rp = AW'(s_r.rp + 1'h1);
		end else if (pop) begin
			s_nxt.ov = 1'h0;
		end
		s_nxt.cnt = (AW+1)'(s_r.cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, refill});
		s_nxt.rdy = (s_nxt.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= FIFO_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_fifo_bound: assert property (s_r.cnt <= (AW+1)'(DEPTH))
		else $error("FIFO count above depth.");
	a_fifo_full_stall: assert property (s_r.cnt == (AW+1)'(DEPTH) |-> !in_s.ready)
		else $error("FIFO ready while full.");
	c_fifo_full: cover property (s_r.cnt == (AW+1)'(DEPTH));
endmodule

//--- hdl/sample_stream_if.sv
// Valid/ready stream of audio samples between the port's own modules.
`timescale 1ns/1ns
interface sample_stream_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- sim/pcm_audio_master_port_test.sv
// Self-checking bench of the serial audio master port with a codec model.
`timescale 1ns/1ns
module pcm_audio_master_port_test
	import pcm_port_pkg::*;
;
	typedef struct packed {
		sample_t tx;
		sample_t cw;
	} row_t;

	logic       SYS_CLK_I = 1'b0;
	logic       SYS_RST_I = 1'b1;
	sample_t    TX_DATA_I = 16'h0000;
	logic       TX_VALID_I = 1'b0;
	logic       TX_READY_O;
	sample_t    RX_DATA_O;
	logic       RX_VALID_O;
	logic       PCM_SYNC_O;
	logic       PCM_CLK_O;
	logic       PCM_DATA_O;
	logic       PCM_DATA_OE_O;
	logic       PCM_DATA_I;
	sample_t    codec_word;
	sample_t    codec_rx;
	logic [6:0] bit_w;
	logic       pc = 1'b0;
	logic       ps = 1'b0;
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         lastr = 0;
	int         lasts = 0;
	int         n;
	int         k;
	logic       rdy;
	// The last row is the silence sent once the buffer has run dry.
	row_t       rows [10] = '{'{16'h8000, 16'h0001}, '{16'h0001, 16'h8000},
		'{16'hFFFF, 16'h0000}, '{16'hA5A5, 16'h5A5A}, '{16'h1234, 16'hFEDC},
		'{16'h0F0F, 16'hC3C3}, '{16'h7FFF, 16'hFFFE}, '{16'h4001, 16'h2002},
		'{16'hBEEF, 16'h0110}, '{16'h0000, 16'h9669}};

	always #5 SYS_CLK_I = ~SYS_CLK_I;

	pcm_audio_master_port pcm_audio_master_port_i (
		.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .TX_DATA_I(TX_DATA_I),
		.TX_VALID_I(TX_VALID_I), .TX_READY_O(TX_READY_O), .RX_DATA_O(RX_DATA_O),
		.RX_VALID_O(RX_VALID_O), .PCM_SYNC_O(PCM_SYNC_O), .PCM_CLK_O(PCM_CLK_O),
		.PCM_DATA_O(PCM_DATA_O), .PCM_DATA_OE_O(PCM_DATA_OE_O), .PCM_DATA_I(PCM_DATA_I));

	pcm_codec_model pcm_codec_model_i (
		.clk_i(SYS_CLK_I), .rst_i(SYS_RST_I), .pcm_clk_i(PCM_CLK_O),
		.pcm_sync_i(PCM_SYNC_O), .pcm_out_i(PCM_DATA_O), .pcm_in_o(PCM_DATA_I),
		.tx_word_i(codec_word), .rx_word_o(codec_rx), .bit_o(bit_w));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_rx();
		int i;
		i = 0;
		do begin
			@(posedge SYS_CLK_I);
			#1;
			i++;
		end while (RX_VALID_O !== 1'b1 && i < 13000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Wire monitor: bit clock period, frame period, sync and slot levels mid-bit.
	always @(posedge SYS_CLK_I) begin
		pc  <= PCM_CLK_O;
		ps  <= PCM_SYNC_O;
		cyc <= cyc + 1;
		if (!SYS_RST_I) begin
			if (PCM_CLK_O && !pc) begin
				if (lastr != 0) chk("clk_period", 1, cyc - lastr inside {130, 131});
				lastr <= cyc;
			end
			if (PCM_SYNC_O && !ps) begin
				if (lasts != 0) chk("frame_period", 12500, cyc - lasts);
				lasts <= cyc;
			end
			if (!PCM_CLK_O && pc && bit_w < 7'h60) begin
				chk("data_oe", bit_w < 7'h10, PCM_DATA_OE_O);
				chk("sync_level", bit_w < 7'h19, PCM_SYNC_O);
				if (bit_w >= 7'h10) chk("idle_data", 0, PCM_DATA_O);
			end
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (cyc == 130000) begin
			error_cnt++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, fill the buffer until refused, then one frame per row.
	initial begin
		codec_word = rows[0].cw;
		repeat (2) @(posedge SYS_CLK_I);
		#1;
		chk("reset_outs", 32'h1, {PCM_SYNC_O, PCM_CLK_O, PCM_DATA_O, PCM_DATA_OE_O,
			RX_VALID_O, TX_READY_O});
		SYS_RST_I  = 1'b0;
		TX_VALID_I = 1'b1;
		TX_DATA_I  = rows[0].tx;
		n = 0;
		repeat (20) begin
			rdy = TX_READY_O;
			@(posedge SYS_CLK_I);
			#1;
			if (rdy === 1'b1) n++;
			TX_DATA_I = rows[(n < 9) ? n : 9].tx;
		end
		TX_VALID_I = 1'b0;
		chk("fifo_accepted", 9, n);
		chk("ready_full", 0, TX_READY_O);
		for (k = 0; k < 10; k++) begin
			wait_rx();
			chk("rx_valid", 1, RX_VALID_O);
			chk("rx_data", rows[k].cw, RX_DATA_O);
			// The codec model sees the falling bit clock one system clock later.
			@(posedge SYS_CLK_I);
			#1;
			chk("codec_rx", rows[k].tx, codec_rx);
			if (k < 9) codec_word = rows[k + 1].cw;
		end
		chk("ready_drained", 1, TX_READY_O);
		print_verdict();
	end
endmodule

//--- sim/pcm_codec_model.sv
// Behavioural model of the external codec on the serial audio link.
`timescale 1ns/1ns
module pcm_codec_model
	import pcm_port_pkg::*;
(
	// System clock and reset used to watch the link.
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// Link pins as seen from the codec.
	input  wire logic  pcm_clk_i,
	input  wire logic  pcm_sync_i,
	input  wire logic  pcm_out_i,
	output logic       pcm_in_o,
	// Word to send each frame, last word received, current bit.
	input  wire sample_t tx_word_i,
	output sample_t    rx_word_o,
	output logic [6:0] bit_o
);
	logic       clk_q;
	logic       sync_q;
	logic [6:0] nb;
	sample_t    sh;

	always @(posedge clk_i) begin
		if (rst_i) begin
			clk_q     <= 1'b0;
			sync_q    <= 1'b0;
			bit_o     <= 7'h7F;
			pcm_in_o  <= 1'b1;
			sh        <= 16'h0000;
			rx_word_o <= 16'h0000;
		end else begin
			clk_q  <= pcm_clk_i;
			sync_q <= pcm_sync_i;
			if (pcm_clk_i && !clk_q) begin
				// Sync rising with the bit clock marks bit 0.
				nb = (pcm_sync_i && !sync_q) ? 7'h00 : bit_o + 7'h01;
				bit_o <= nb;
				// Outside slot 0 the line floats to its pull-up level.
				pcm_in_o <= (nb < 7'h10) ? tx_word_i[4'hF - nb[3:0]] : 1'b1;
			end
			if (!pcm_clk_i && clk_q && bit_o < 7'h10) begin
				sh <= {sh[14:0], pcm_out_i};
				if (bit_o == 7'h0F) begin
					rx_word_o <= {sh[14:0], pcm_out_i};
				end
			end
		end
	end
endmodule
